// >>> psta_flash_model.sv
/*
  Flash array model facing the table access block: read data one cycle
  after a read pulse, write latches, self-timed page erase and
  double-word program ending in a done pulse.
  Assumes the block's request struct on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module psta_flash_model #(
  parameter int DLY = 12
) (
  input wire logic clk_i,
  input wire psta_pkg::psta_fa_req_t req_i,
  output logic [23:0] rdata_o,
  output logic done_o
);
  logic [23:0] mem [int];
  logic [23:0] lat [int];
  logic [23:0] last_rd = 24'h00_0000;
  logic [23:0] last_ad = 24'h00_0000;
  int n_er = 0;
  int n_pg = 0;
  int n_wr = 0;
  int n_done = 0;
  int cnt = 0;
  int dq [$];
  initial begin
    rdata_o = 24'h00_0000;
    done_o = 1'b0;
  end
  always @(posedge clk_i) begin
    int a;
    a = int'(req_i.addr);
    // Idle read bus toggles so a stale value never passes
    rdata_o <= ~rdata_o;
    done_o <= 1'b0;
    if (req_i.rd) begin
      last_rd <= req_i.addr;
      rdata_o <= mem.exists(a) ? mem[a] : 24'hFF_FFFF;
    end
    if (req_i.wr) begin
      n_wr++;
      if (!lat.exists(a)) lat[a] = 24'hFF_FFFF;
      for (int b = 0; b < 3; b++) if (req_i.lane[b]) lat[a][b*8+:8] = req_i.wdata[b*8+:8];
    end
    if (req_i.erase) begin
      n_er++;
      last_ad <= req_i.addr;
      // Page spans 1024 words of two address steps each
      foreach (mem[k]) if ((k & 32'h00FF_F800) == (a & 32'h00FF_F800)) dq.push_back(k);
      while (dq.size() > 0) mem.delete(dq.pop_front());
      cnt = DLY;
    end else if (req_i.prog) begin
      n_pg++;
      last_ad <= req_i.addr;
      // Two adjacent words committed together
      for (int w = 0; w < 2; w++) if (lat.exists(a + 2*w)) mem[a + 2*w] = lat[a + 2*w];
      cnt = DLY;
    end else if (cnt > 0) begin
      cnt--;
      if (cnt == 0) begin
        done_o <= 1'b1;
        n_done++;
      end
    end
  end
endmodule
`default_nettype wire

// >>> psta_params.svh
/*
  Constants of the program space table access block: register offsets,
  bit positions, operation codes and address masks.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PSTA_PARAMS_SVH
`define PSTA_PARAMS_SVH
`define PSTA_OFF_PAGE 16'h0000
`define PSTA_OFF_CTRL 16'h0004
`define PSTA_OFF_KEY 16'h0008
`define PSTA_OFF_NVADR 16'h000C
`define PSTA_OFF_EA 16'h0010
`define PSTA_OFF_DATA 16'h0014
`define PSTA_OFF_CMD 16'h0018
`define PSTA_PSV_BIT 16
`define PSTA_CTRL_START 15
`define PSTA_CTRL_EN 14
`define PSTA_CTRL_ERR 13
`define PSTA_CMD_HI 0
`define PSTA_CMD_WR 1
`define PSTA_CMD_BYTE 2
`define PSTA_CMD_INC 3
`define PSTA_PAGE_MSB 7
`define PSTA_OP_ERASE 4'h3
`define PSTA_OP_PROG 4'h1
`define PSTA_KEY_FIRST 8'h55
`define PSTA_KEY_SECOND 8'hAA
`define PSTA_EA_STEP 16'h0002
`define PSTA_WORD_MASK 24'hFF_FFFE
`define PSTA_PROG_MASK 24'hFF_FFFC
`define PSTA_PAGE_MASK 24'hFF_F800
`define PSTA_PAGE_OFFS 24'h00_07FF
`define PSTA_LANE_LOW 3'h1
`define PSTA_LANE_MID 3'h2
`define PSTA_LANE_WORD 3'h3
`define PSTA_LANE_HIGH 3'h4
`define PSTA_LANE_NONE 3'h0
`endif

// >>> psta_pkg.sv
/*
  Types of the program space table access block.
  Assumes psta_params.svh for the numeric constants.
*/
package psta_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RD_ISSUE, ST_RD_TAKE, ST_FL_WAIT} psta_state_t;
  typedef enum logic [1:0] {KEY_NONE, KEY_HALF, KEY_ARMED} psta_key_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic prog;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [2:0] lane;
  } psta_fa_req_t;
  typedef struct packed {
    logic hi;
    logic byte_mode;
    logic bsel;
    logic psv;
  } psta_rd_kind_t;
endpackage

// >>> psta_table_access.sv
/*
  Program space table access: Wishbone classic slave giving the CPU table
  reads and writes of the 24-bit program array, a read-only visibility
  window, and self-timed page erase and double-word program.
  Assumes a flash array on the same clock: read data valid the cycle after
  rd, done pulse when an erase or program ends.
*/
// The address map and the Wishbone register port were decided locally.
// Behaviour
// - Address is page byte above effective address
// - Page top bit selects user or configuration
// - Program address bit zero always forced low
// - Unaligned and configuration table accesses accepted
// - Successive program words step address by two
// - Low word read returns bits fifteen to zero
// - Low byte read picks byte by select
// - High word read zeroes upper data byte
// - High byte read phantom byte reads zero
// - High reads and writes reach bits 23:16
// - Low reads and writes reach bits 15:0
// - Visibility window is read only, low word
// - Erase whole pages of 1024 words
// - Program two instruction words at once
// - Processor stalls until flash operation ends
// - Start bit begins operation, hardware clears it
// - Code 0011 erases page, 0001 programs
// - No erase or program without enable bit
`timescale 1ns/100ps
`default_nettype none
`include "psta_params.svh"
module psta_table_access (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [16:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output psta_pkg::psta_fa_req_t fa_req_o,
  input wire logic [23:0] fa_rdata_i,
  input wire logic fa_done_i,
  output logic cpu_stall_o
);
  psta_pkg::psta_state_t state_reg;
  psta_pkg::psta_key_t key_reg;
  psta_pkg::psta_fa_req_t fa_reg;
  psta_pkg::psta_rd_kind_t rkind_reg;
  logic ack_reg;
  logic stall_reg;
  logic [31:0] dat_reg;
  logic [7:0] tpage_reg;
  logic [15:0] ea_reg;
  logic [15:0] tdata_reg;
  logic [23:0] nvadr_reg;
  logic busy_reg;
  logic en_reg;
  logic err_reg;
  logic [3:0] op_reg;

  logic req;
  logic wr;
  logic psv;
  logic [15:0] radr;
  logic cmd_wr;
  logic tbl_rd;
  logic tbl_wr;
  logic psv_rd;
  logic start_wr;
  logic [3:0] op_next;
  logic op_ok;
  logic go_flash;
  logic bad_start;
  logic [23:0] tbl_addr;
  logic [23:0] psv_addr;
  logic [15:0] rd_mapped;
  logic [31:0] rdata;
  logic [15:0] wmask;

  function automatic logic [15:0] rd_map(input logic hi, input logic bm, input logic bs,
                                          input logic [23:0] p);
    if (!hi) begin
      rd_map = !bm ? p[15:0] : {8'h00, bs ? p[15:8] : p[7:0]};
    end else begin
      rd_map = (bm && bs) ? 16'h0000 : {8'h00, p[23:16]};
    end
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~ack_reg & (state_reg == psta_pkg::ST_IDLE);
  assign wr = req & wb_we_i;
  assign psv = wb_adr_i[`PSTA_PSV_BIT];
  assign radr = wb_adr_i[15:0];
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign cmd_wr = wr & ~psv & (radr == `PSTA_OFF_CMD) & wb_sel_i[0];
  assign tbl_rd = cmd_wr & ~wb_dat_i[`PSTA_CMD_WR];
  assign tbl_wr = cmd_wr & wb_dat_i[`PSTA_CMD_WR];
  // Visibility window reads only; writes into it are acked and dropped
  assign psv_rd = req & ~wb_we_i & psv;
  assign start_wr = wr & ~psv & (radr == `PSTA_OFF_CTRL) & wb_sel_i[1]
                    & wb_dat_i[`PSTA_CTRL_START];
  assign op_next = wb_sel_i[0] ? wb_dat_i[3:0] : op_reg;
  assign op_ok = (op_next == `PSTA_OP_ERASE) | (op_next == `PSTA_OP_PROG);
  assign go_flash = start_wr & (key_reg == psta_pkg::KEY_ARMED)
                    & wb_dat_i[`PSTA_CTRL_EN] & op_ok;
  assign bad_start = start_wr & ~go_flash;
  // Page byte on top, effective address below, bit zero forced low; any
  // page value is accepted, so unaligned and configuration accesses pass
  assign tbl_addr = {tpage_reg, ea_reg}
                    & `PSTA_WORD_MASK;
  assign psv_addr = {tpage_reg, radr} & `PSTA_WORD_MASK;
  assign rd_mapped = rd_map(rkind_reg.hi, rkind_reg.byte_mode, rkind_reg.bsel, fa_rdata_i);

  always_comb begin
    unique case (radr)
      `PSTA_OFF_PAGE: rdata = {24'h00_0000, tpage_reg};
      `PSTA_OFF_CTRL: rdata = {16'h0000, busy_reg, en_reg, err_reg, 9'h000, op_reg};
      `PSTA_OFF_NVADR: rdata = {8'h00, nvadr_reg};
      `PSTA_OFF_EA: rdata = {16'h0000, ea_reg};
      `PSTA_OFF_DATA: rdata = {16'h0000, tdata_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Bus sequencing; flash operations hold the ack back, stalling the master
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= psta_pkg::ST_IDLE;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      rkind_reg <= '0;
    end else if (ce_i) begin
      ack_reg <= 1'b0;
      unique case (state_reg)
        psta_pkg::ST_IDLE: begin
          if (tbl_rd || psv_rd) begin
            state_reg <= psta_pkg::ST_RD_ISSUE;
            rkind_reg.hi <= psv ? 1'b0 : wb_dat_i[`PSTA_CMD_HI];
            rkind_reg.byte_mode <= psv ? 1'b0 : wb_dat_i[`PSTA_CMD_BYTE];
            rkind_reg.bsel <= psv ? 1'b0 : ea_reg[0];
            rkind_reg.psv <= psv;
          end else if (go_flash) begin
            state_reg <= psta_pkg::ST_FL_WAIT;
          end else if (req) begin
            ack_reg <= 1'b1;
            dat_reg <= (wb_we_i || psv) ? 32'h0000_0000 : rdata;
          end
        end
        psta_pkg::ST_RD_ISSUE: state_reg <= psta_pkg::ST_RD_TAKE;
        psta_pkg::ST_RD_TAKE: begin
          // Fixed three-edge read, phantom byte already zeroed by the map
          state_reg <= psta_pkg::ST_IDLE;
          ack_reg <= 1'b1;
          dat_reg <= rkind_reg.psv ? {16'h0000, rd_mapped} : 32'h0000_0000;
        end
        psta_pkg::ST_FL_WAIT: begin
          if (fa_done_i) begin
            state_reg <= psta_pkg::ST_IDLE;
            ack_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // Requests to the flash array; strobes last one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fa_reg <= '0;
    end else if (ce_i) begin
      fa_reg.rd <= tbl_rd | psv_rd;
      fa_reg.wr <= 1'b0;
      fa_reg.erase <= 1'b0;
      fa_reg.prog <= 1'b0;
      if (tbl_rd) begin
        fa_reg.addr <= tbl_addr;
      end else if (psv_rd) begin
        fa_reg.addr <= psv_addr;
      end else if (tbl_wr) begin
        fa_reg.addr <= tbl_addr;
        if (wb_dat_i[`PSTA_CMD_HI]) begin
          // Phantom byte write has no lane and never reaches the array
          fa_reg.wr <= ~(wb_dat_i[`PSTA_CMD_BYTE] & ea_reg[0]);
          fa_reg.lane <= (wb_dat_i[`PSTA_CMD_BYTE] & ea_reg[0]) ? `PSTA_LANE_NONE
                         : `PSTA_LANE_HIGH;
          fa_reg.wdata <= {tdata_reg[7:0], 16'h0000};
        end else begin
          fa_reg.wr <= 1'b1;
          fa_reg.lane <= !wb_dat_i[`PSTA_CMD_BYTE] ? `PSTA_LANE_WORD
                         : (ea_reg[0] ? `PSTA_LANE_MID : `PSTA_LANE_LOW);
          fa_reg.wdata <= wb_dat_i[`PSTA_CMD_BYTE]
                          ? {8'h00, tdata_reg[7:0], tdata_reg[7:0]}
                          : {8'h00, tdata_reg};
        end
      end else if (go_flash) begin
        fa_reg.erase <= (op_next == `PSTA_OP_ERASE);
        fa_reg.prog <= (op_next == `PSTA_OP_PROG);
        // Erase takes the whole page, program the aligned word pair
        fa_reg.addr <= (op_next == `PSTA_OP_ERASE) ? (nvadr_reg & `PSTA_PAGE_MASK)
                       : (nvadr_reg & `PSTA_PROG_MASK);
        fa_reg.lane <= `PSTA_LANE_NONE;
      end
    end
  end

  // Unlock key: 0x55 then 0xAA on consecutive writes; any other write disarms
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      key_reg <= psta_pkg::KEY_NONE;
    end else if (ce_i && wr) begin
      if (!psv && radr == `PSTA_OFF_KEY && wb_sel_i[0]) begin
        if (wb_dat_i[7:0] == `PSTA_KEY_FIRST) begin
          key_reg <= psta_pkg::KEY_HALF;
        end else if (key_reg == psta_pkg::KEY_HALF && wb_dat_i[7:0] == `PSTA_KEY_SECOND) begin
          key_reg <= psta_pkg::KEY_ARMED;
        end else begin
          key_reg <= psta_pkg::KEY_NONE;
        end
      end else begin
        key_reg <= psta_pkg::KEY_NONE;
      end
    end
  end

  // Control register: start, enable, error flag, operation select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      en_reg <= 1'b0;
      err_reg <= 1'b0;
      op_reg <= 4'h0;
      stall_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr && !psv && radr == `PSTA_OFF_CTRL) begin
        if (wb_sel_i[1]) begin
          en_reg <= wb_dat_i[`PSTA_CTRL_EN];
        end
        if (wb_sel_i[0]) begin
          op_reg <= wb_dat_i[3:0];
        end
      end
      if (bad_start) begin
        err_reg <= 1'b1;
      end else if (go_flash) begin
        err_reg <= 1'b0;
      end else if (wr && !psv && radr == `PSTA_OFF_CTRL && wb_sel_i[1]) begin
        err_reg <= wb_dat_i[`PSTA_CTRL_ERR];
      end
      if (go_flash) begin
        busy_reg <= 1'b1;
        stall_reg <= 1'b1;
      end else if (state_reg == psta_pkg::ST_FL_WAIT && fa_done_i) begin
        busy_reg <= 1'b0;
        stall_reg <= 1'b0;
      end
    end
  end

  // Table page, effective address, data and flash address registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tpage_reg <= 8'h00;
      ea_reg <= 16'h0000;
      tdata_reg <= 16'h0000;
      nvadr_reg <= 24'h00_0000;
    end else if (ce_i) begin
      if (wr && !psv) begin
        if (radr == `PSTA_OFF_PAGE && wb_sel_i[0]) begin
          tpage_reg <= wb_dat_i[7:0];
        end
        if (radr == `PSTA_OFF_EA) begin
          ea_reg <= (ea_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
        end
        if (radr == `PSTA_OFF_DATA) begin
          tdata_reg <= (tdata_reg & ~wmask) | (wb_dat_i[15:0] & wmask);
        end
        if (radr == `PSTA_OFF_NVADR) begin
          nvadr_reg <= {wb_sel_i[2] ? wb_dat_i[23:16] : nvadr_reg[23:16],
                        (nvadr_reg[15:0] & ~wmask) | (wb_dat_i[15:0] & wmask)};
        end
      end
      if (cmd_wr && wb_dat_i[`PSTA_CMD_INC]) begin
        ea_reg <= ea_reg + `PSTA_EA_STEP;
      end
      if (state_reg == psta_pkg::ST_RD_TAKE && !rkind_reg.psv) begin
        tdata_reg <= rd_mapped;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign fa_req_o = fa_reg;
  assign cpu_stall_o = stall_reg;

  a_addr_lsb_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (fa_reg.rd || fa_reg.wr || fa_reg.erase || fa_reg.prog) |-> !fa_reg.addr[0])
    else $error("flash address bit zero set");
  a_page_on_top: assert property (@(posedge clk_i) disable iff (rst_i)
    (fa_reg.rd || fa_reg.wr) |-> fa_reg.addr[23:16] == tpage_reg)
    else $error("table address page byte wrong");
  a_space_select: assert property (@(posedge clk_i) disable iff (rst_i)
    fa_reg.rd |-> fa_reg.addr[23] == tpage_reg[`PSTA_PAGE_MSB])
    else $error("table access in wrong space");
  a_phantom_zero: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (state_reg == psta_pkg::ST_RD_TAKE && !rkind_reg.psv && rkind_reg.hi
     && rkind_reg.byte_mode && rkind_reg.bsel) |=> tdata_reg == 16'h0000)
    else $error("phantom byte not zero");
  a_read_no_write: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (tbl_rd || psv_rd) |=> !fa_reg.wr && !fa_reg.erase && !fa_reg.prog ##1 !fa_reg.wr ##1
    wb_ack_o)
    else $error("table read wrote array or missed its latency");
  a_bad_start_err: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    bad_start |=> err_reg && !fa_reg.erase && !fa_reg.prog && !busy_reg)
    else $error("bad start not flagged or flash touched");
  a_stall_held: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (state_reg == psta_pkg::ST_FL_WAIT && !fa_done_i) |=> cpu_stall_o && !wb_ack_o)
    else $error("stall released before flash done");
  a_start_cleared: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (state_reg == psta_pkg::ST_FL_WAIT && fa_done_i) |=> !busy_reg && wb_ack_o && !cpu_stall_o)
    else $error("start bit not cleared at done");
  a_erase_page: assert property (@(posedge clk_i) disable iff (rst_i)
    fa_reg.erase |-> (fa_reg.addr & `PSTA_PAGE_OFFS) == 24'h00_0000 && !fa_reg.prog)
    else $error("erase not page aligned");
  a_enable_gate: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    (start_wr && !wb_dat_i[`PSTA_CTRL_EN]) |=> !fa_reg.erase && !fa_reg.prog)
    else $error("flash operation without enable");
endmodule
`default_nettype wire

// >>> psta_table_access_bench.sv
/*
  Self-checking bench for the table access block over Wishbone.
  Assumes psta_flash_model as the array and psta_params.svh offsets.
*/
`timescale 1ns/100ps
`default_nettype none
`include "psta_params.svh"
module psta_table_access_bench;
  localparam int DLY = 12;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [16:0] adr = 17'h0_0000;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack;
  logic stall;
  logic done;
  logic [23:0] rdata;
  psta_pkg::psta_fa_req_t fa_req;
  int errors = 0;
  int checked = 0;
  int stall_n = 0;
  logic [31:0] q;
  logic [15:0] ex [8] = '{16'h1234, 16'h1234, 16'h0034, 16'h0012,
                          16'h0056, 16'h0056, 16'h0056, 16'h0000};
  always #25 clk = ~clk;
  always @(posedge clk) if (stall === 1'b1) stall_n++;
  psta_table_access i_dut (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_i),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .fa_req_o(fa_req), .fa_rdata_i(rdata),
    .fa_done_i(done), .cpu_stall_o(stall));
  psta_flash_model #(.DLY(DLY)) i_fm (.clk_i(clk), .req_i(fa_req), .rdata_o(rdata),
    .done_o(done));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [16:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 2000);
    r = dat_o;
    if (n >= 2000) begin
      errors++;
      print_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, {1'b0, a}, d, r);
  endtask
  task automatic rd(input logic [16:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0000_0000, r);
  endtask
  task automatic tread(input logic [15:0] ea, input logic [3:0] cmd, output logic [31:0] r);
    wr(`PSTA_OFF_EA, {16'h0000, ea});
    wr(`PSTA_OFF_CMD, {28'h000_0000, cmd});
    rd({1'b0, `PSTA_OFF_DATA}, r);
  endtask
  task automatic go(input logic [15:0] ctl);
    wr(`PSTA_OFF_KEY, 32'h0000_0055);
    wr(`PSTA_OFF_KEY, 32'h0000_00AA);
    wr(`PSTA_OFF_CTRL, {16'h0000, ctl});
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd({1'b0, `PSTA_OFF_CTRL}, q);
    chk("ctrl reset", 32'h0000_0000, q);
    rd({1'b0, `PSTA_OFF_KEY}, q);
    chk("key read", 32'h0000_0000, q);
    rd(17'h0_001C, q);
    chk("unmapped read", 32'h0000_0000, q);
    $display("test reset done");
    // Fill two write latches, then program them as one double word
    wr(`PSTA_OFF_PAGE, 32'h0000_0000);
    wr(`PSTA_OFF_EA, 32'h0000_1004);
    wr(`PSTA_OFF_DATA, 32'h0000_1234);
    wr(`PSTA_OFF_CMD, 32'h0000_0002);
    wr(`PSTA_OFF_DATA, 32'h0000_0056);
    wr(`PSTA_OFF_CMD, 32'h0000_0003);
    wr(`PSTA_OFF_EA, 32'h0000_1006);
    wr(`PSTA_OFF_DATA, 32'h0000_BEEF);
    wr(`PSTA_OFF_CMD, 32'h0000_0002);
    wr(`PSTA_OFF_NVADR, 32'h0000_1006);
    go(16'hC001);
    chk("program count", 32'h1, 32'(i_fm.n_pg));
    chk("program addr", 32'h0000_1004, {8'h00, i_fm.last_ad});
    chk("done before ack", 32'h1, 32'(i_fm.n_done));
    chk("stall length", 32'h1, 32'(stall_n >= DLY));
    chk("stall released", 32'h0, {31'h0000_0000, stall});
    rd({1'b0, `PSTA_OFF_CTRL}, q);
    chk("ctrl after program", 32'h0000_4001, q);
    $display("test program done");
    for (int k = 0; k < 8; k++) begin
      tread(16'h1004 | 16'(k & 1), {1'b0, k[1], 1'b0, k[2]}, q);
      chk("table read", {16'h0000, ex[k]}, q);
    end
    chk("read addr", 32'h0000_1004, {8'h00, i_fm.last_rd});
    tread(16'h1004, 4'h8, q);
    chk("incr read", 32'h0000_1234, q);
    rd({1'b0, `PSTA_OFF_EA}, q);
    chk("ea step", 32'h0000_1006, q);
    wr(`PSTA_OFF_CMD, 32'h0000_0000);
    rd({1'b0, `PSTA_OFF_DATA}, q);
    chk("second word", 32'h0000_BEEF, q);
    chk("no write on read", 32'h3, 32'(i_fm.n_wr));
    // High byte write to the phantom byte must not reach the array
    wr(`PSTA_OFF_EA, 32'h0000_1007);
    wr(`PSTA_OFF_CMD, 32'h0000_0007);
    chk("phantom write", 32'h3, 32'(i_fm.n_wr));
    $display("test table read done");
    wr(`PSTA_OFF_PAGE, 32'h0000_0080);
    tread(16'h0001, 4'h0, q);
    chk("config read", 32'h0000_FFFF, q);
    chk("config addr", 32'h0080_0000, {8'h00, i_fm.last_rd});
    wr(`PSTA_OFF_PAGE, 32'h0000_0000);
    rd(17'h1_1006, q);
    chk("window read", 32'h0000_BEEF, q);
    wb(1'b1, 17'h1_1006, 32'h0000_0000, q);
    chk("window write", 32'h3, 32'(i_fm.n_wr));
    rd(17'h1_1006, q);
    chk("window after write", 32'h0000_BEEF, q);
    $display("test window done");
    wr(`PSTA_OFF_CTRL, 32'h0000_C003);
    rd({1'b0, `PSTA_OFF_CTRL}, q);
    chk("start without key", 32'h0000_6003, q);
    go(16'h8003);
    rd({1'b0, `PSTA_OFF_CTRL}, q);
    chk("start disabled", 32'h0000_2003, q);
    go(16'hC005);
    rd({1'b0, `PSTA_OFF_CTRL}, q);
    chk("reserved code", 32'h0000_6005, q);
    wr(`PSTA_OFF_KEY, 32'h0000_0055);
    wr(`PSTA_OFF_PAGE, 32'h0000_0000);
    wr(`PSTA_OFF_KEY, 32'h0000_00AA);
    wr(`PSTA_OFF_CTRL, 32'h0000_C003);
    rd({1'b0, `PSTA_OFF_CTRL}, q);
    chk("broken key", 32'h0000_6003, q);
    chk("no flash op", 32'h0, 32'(i_fm.n_er));
    $display("test bad start done");
    wr(`PSTA_OFF_NVADR, 32'h0000_1400);
    go(16'hC003);
    chk("erase count", 32'h1, 32'(i_fm.n_er));
    chk("erase addr", 32'h0000_1000, {8'h00, i_fm.last_ad});
    rd({1'b0, `PSTA_OFF_CTRL}, q);
    chk("error cleared", 32'h0000_4003, q);
    tread(16'h1004, 4'h0, q);
    chk("erased word", 32'h0000_FFFF, q);
    $display("test erase done");
    print_verdict();
  end
endmodule
`default_nettype wire
